// ===== pt_port_filter.sv
// 8-bit general-purpose port with input noise eliminators
// assumes all pins are asynchronous to core_clk; all but the irq_wake gate are synchronised here;
// alternate-function outputs and count enables come from core_clk logic
`default_nettype none
module pt_port_filter
  import pt_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  // port pins
  input wire logic [PORT_W-1:0] port_pin_i,
  output logic [PORT_W-1:0] port_pin_o,
  output logic [PORT_W-1:0] port_pin_oe,
  // alternate functions of the port pins
  input wire logic [PORT_W-1:0] alt_out,
  // port data register access
  input wire logic port_wr,
  input wire logic [PORT_W-1:0] port_wdata,
  input wire logic [1:0] port_bit_op,
  input wire logic [IDX_W-1:0] port_bit_idx,
  input wire logic port_rd,
  output logic [PORT_W-1:0] port_rdata,
  output logic port_rvalid,
  // direction and function select registers
  input wire logic dir_wr,
  input wire logic [PORT_W-1:0] dir_wdata,
  input wire logic fsel_wr,
  input wire logic [PORT_W-1:0] fsel_wdata,
  output logic [PORT_W-1:0] port_direction_register,
  output logic [PORT_W-1:0] port_function_select_register,
  // filter configuration register access
  input wire logic cfg_wr,
  input wire logic cfg_bit_wr,
  input wire logic [3:0] cfg_sel,
  input wire logic [7:0] cfg_wdata,
  input wire logic [IDX_W-1:0] cfg_bit_idx,
  input wire logic cfg_bit_val,
  input wire logic cfg_rd,
  output logic [7:0] cfg_rdata,
  output logic cfg_rvalid,
  // interrupt pins
  input wire logic [IRQ_N-1:0] irq_pin_i,
  input wire logic [IRQ_N-1:0] irq_ctrl_mode,
  output logic [IRQ_N-1:0] irq_level,
  output logic [IRQ_N-1:0] irq_wake,
  // timer 10, 11, 3 inputs
  input wire logic [TM_N-1:0] tm_pin_i,
  input wire logic [TM_N-1:0] tm_ctrl_mode,
  input wire logic [TM_N-1:0] tm_count_enable,
  output logic [TM_N-1:0] tm_level,
  // timer 2 inputs
  input wire logic [T2_N-1:0] t2_pin_i,
  input wire logic [T2_N-1:0] t2_ctrl_mode,
  input wire logic [T2_N-1:0] timer2_channel_count_enable,
  output logic [T2_N-1:0] t2_level,
  output logic [T2_N-1:0] t2_edge
);
  // ==========================================================
  // state
  typedef struct packed {
    logic [PORT_W-1:0] latch; // output latch
    logic [PORT_W-1:0] dir; // 1 = output
    logic [PORT_W-1:0] fsel; // 1 = control mode
    logic [TM_N-1:0][7:0] clk_sel; // timer clock selects
    logic [T2_N-1:0][7:0] t2_mode; // timer 2 filter modes
    logic [PORT_W-1:0] pin_meta; // synchroniser stage 1
    logic [PORT_W-1:0] pin_sync; // synchroniser stage 2
    logic [IRQ_N-1:0] irq_meta;
    logic [IRQ_N-1:0] irq_sync;
    logic [TM_N-1:0] tm_meta;
    logic [TM_N-1:0] tm_sync;
    logic [T2_N-1:0] t2_meta;
    logic [T2_N-1:0] t2_sync;
    logic [T2_N-1:0] t2_prev; // last level for edges
    logic [T2_N-1:0] t2_edge; // edge pulses
    logic [PORT_W-1:0] rdata; // port read result
    logic rvalid;
    logic [7:0] cfg_rdata; // config read result
    logic cfg_rvalid;
  } pt_port_s;
  pt_port_s st_ff; // registered state
  pt_port_s nxt_st; // next state

  // ==========================================================
  // helper functions
  // what a read of the port data register sees, per bit
  function automatic logic [PORT_W-1:0] port_view(
    input logic [PORT_W-1:0] latch,
    input logic [PORT_W-1:0] dir,
    input logic [PORT_W-1:0] fsel,
    input logic [PORT_W-1:0] pin,
    input logic [PORT_W-1:0] alt
  );
    logic [PORT_W-1:0] outv;
    outv = (fsel & alt) | (~fsel & latch);
    return (dir & outv) | (~dir & pin);
  endfunction

  // does this edge match the selected valid edge
  // mode zero keeps the edge output quiet
  function automatic logic edge_hit(
    input logic [1:0] mode,
    input logic prev,
    input logic cur
  );
    logic hit;
    hit = 1'b0;
    unique case (pt_edge_e'(mode))
      PT_EDGE_NONE: hit = 1'b0;
      PT_EDGE_RISE: hit = !prev && cur;
      PT_EDGE_FALL: hit = prev && !cur;
      PT_EDGE_BOTH: hit = prev != cur;
    endcase
    return hit;
  endfunction

  // one bit written into a byte
  // shared by the bit ops and the filter registers
  function automatic logic [7:0] bit_put(
    input logic [7:0] val,
    input logic [IDX_W-1:0] idx,
    input logic b
  );
    logic [7:0] r;
    r = val;
    r[idx] = b;
    return r;
  endfunction

  // ==========================================================
  // sampling ticks and filters
  logic [TICK_N-1:0] tick; // divider ticks
  logic [IRQ_N-1:0] irq_flt; // filtered interrupt levels
  logic [TM_N-1:0] tm_flt; // filtered timer levels
  logic [T2_N-1:0] t2_flt; // digital filter results
  logic [T2_N-1:0] t2_cur; // timer 2 level after filter choice

  // one shared divider keeps the timer and timer 2 filters' ticks in phase
  pt_tick_gen u_tick (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .tick(tick)
  );

  // interrupt pins: fixed elimination time, filter off in port mode
  for (genvar i = 0; i < IRQ_N; i++) begin : g_irq
    pt_sample_filter #(.SAMPLES(IRQ_ELIM_CYC)) u_flt (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .run(irq_ctrl_mode[i]),
      .tick(1'b1),
      .din(st_ff.irq_sync[i]),
      .dout(irq_flt[i])
    );
  end

  // timer 10/11/3: tick chosen by each timer's own register
  for (genvar i = 0; i < TM_N; i++) begin : g_tm
    pt_sample_filter #(.SAMPLES(TM_ELIM_SAMPLES)) u_flt (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .run(tm_ctrl_mode[i] && tm_count_enable[i]),
      .tick(tick[st_ff.clk_sel[i][SEL_MSB:SEL_LSB]]),
      .din(st_ff.tm_sync[i]),
      .dout(tm_flt[i])
    );
  end

  // timer 2: digital stage on the synchronised level
  for (genvar i = 0; i < T2_N; i++) begin : g_t2
    pt_sample_filter #(.SAMPLES(TM_ELIM_SAMPLES)) u_flt (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .run(t2_ctrl_mode[i] && timer2_channel_count_enable[i]),
      .tick(tick[st_ff.t2_mode[i][SEL_MSB:SEL_LSB]]),
      .din(st_ff.t2_sync[i]),
      .dout(t2_flt[i])
    );
  end

  // timer 2 level: the synchroniser stands in for the analog stage,
  // the digital stage is added only when the mode register asks
  always_comb begin
    for (int i = 0; i < T2_N; i++) begin
      t2_cur[i] = st_ff.t2_mode[i][T2_DIG_BIT] ? t2_flt[i] : st_ff.t2_sync[i];
    end
  end

  // ==========================================================
  // next-state logic
  always_comb begin
    logic [PORT_W-1:0] view;
    logic [7:0] cfg_old;
    logic [7:0] cfg_new;
    logic [3:0] t2_idx;
    view = BYTE_ZERO;
    cfg_old = CFG_RST;
    cfg_new = CFG_RST;
    t2_idx = 4'h0;
    nxt_st = st_ff;
    // synchronisers: stage 2 is the only reader of stage 1
    nxt_st.pin_meta = port_pin_i;
    nxt_st.pin_sync = st_ff.pin_meta;
    nxt_st.irq_meta = irq_pin_i;
    nxt_st.irq_sync = st_ff.irq_meta;
    nxt_st.tm_meta = tm_pin_i;
    nxt_st.tm_sync = st_ff.tm_meta;
    nxt_st.t2_meta = t2_pin_i;
    nxt_st.t2_sync = st_ff.t2_meta;

    // current view of the port, also the base of bit operations
    view = port_view(st_ff.latch, st_ff.dir, st_ff.fsel, st_ff.pin_sync, alt_out);

    // port data writes; a byte write wins over a bit operation
    if (port_wr) begin
      nxt_st.latch = port_wdata;
    end else begin
      // input bits take their pin level, as a byte access would
      unique case (pt_bitop_e'(port_bit_op))
        PT_OP_NONE: nxt_st.latch = st_ff.latch;
        PT_OP_SET: nxt_st.latch = bit_put(view, port_bit_idx, 1'b1);
        PT_OP_CLR: nxt_st.latch = bit_put(view, port_bit_idx, 1'b0);
        PT_OP_INV: nxt_st.latch = bit_put(view, port_bit_idx, !view[port_bit_idx]);
      endcase
    end

    // direction and function select
    if (dir_wr) begin
      nxt_st.dir = dir_wdata;
    end
    if (fsel_wr) begin
      nxt_st.fsel = fsel_wdata;
    end

    // port read, answered next cycle; the latch is not touched
    // rdata keeps the last answer until the next read
    nxt_st.rvalid = port_rd;
    if (port_rd) begin
      nxt_st.rdata = view;
    end

    // configuration register file, byte or single bit
    // selects 0..2 timer clocks, 3..8 timer 2 modes;
    // an unmapped select reads zero and ignores writes
    unique case (cfg_sel)
      CFG_TM10: cfg_old = st_ff.clk_sel[0];
      CFG_TM11: cfg_old = st_ff.clk_sel[1];
      CFG_TM3: cfg_old = st_ff.clk_sel[2];
      default: begin
        // timer 2 range or unmapped
        if (cfg_sel >= CFG_T2_BASE && cfg_sel <= CFG_LAST) begin
          t2_idx = cfg_sel - CFG_T2_BASE;
          cfg_old = st_ff.t2_mode[t2_idx[2:0]];
        end else begin
          cfg_old = CFG_RST;
        end
      end
    endcase
    cfg_new = cfg_bit_wr ? bit_put(cfg_old, cfg_bit_idx, cfg_bit_val) : cfg_wdata;
    if (cfg_wr || cfg_bit_wr) begin
      // unmapped selects are ignored
      if (cfg_sel < CFG_T2_BASE) begin
        nxt_st.clk_sel[cfg_sel[1:0]] = cfg_new;
      end else if (cfg_sel <= CFG_LAST) begin
        nxt_st.t2_mode[t2_idx[2:0]] = cfg_new;
      end
    end
    nxt_st.cfg_rvalid = cfg_rd;
    if (cfg_rd) begin
      nxt_st.cfg_rdata = cfg_old;
    end

    // timer 2 edges, only while the channel is counting in control mode
    // prev tracks the level even while stopped, so a change
    // made while stopped raises no edge on restart while the digital stage is off
    for (int i = 0; i < T2_N; i++) begin
      nxt_st.t2_prev[i] = t2_cur[i];
      nxt_st.t2_edge[i] = t2_ctrl_mode[i] && timer2_channel_count_enable[i]
        && edge_hit(st_ff.t2_mode[i][T2_EDGE_MSB:T2_EDGE_LSB], st_ff.t2_prev[i], t2_cur[i]);
    end
  end

  // ==========================================================
  // state register
  // sync reset; fields not named here clear with the struct
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_ff <= '0;
      st_ff.latch <= LATCH_RST;
      st_ff.dir <= DIR_RST;
      st_ff.fsel <= FSEL_RST;
      st_ff.clk_sel <= '0;
      st_ff.t2_mode <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // outputs
  // pin drive: latch in port mode, alternate function in control mode
  always_comb begin
    for (int i = 0; i < PORT_W; i++) begin
      port_pin_o[i] = st_ff.fsel[i] ? alt_out[i] : st_ff.latch[i];
      port_pin_oe[i] = st_ff.dir[i];
    end
  end

  // wake path is a plain gate so standby release works with the
  // clock stopped; it carries no filtering of its own
  assign irq_wake = irq_pin_i & irq_ctrl_mode;

  assign irq_level = irq_flt;
  assign tm_level = tm_flt;
  assign t2_level = t2_cur & t2_ctrl_mode;
  assign t2_edge = st_ff.t2_edge;
  assign port_rdata = st_ff.rdata;
  assign port_rvalid = st_ff.rvalid;
  assign cfg_rdata = st_ff.cfg_rdata;
  assign cfg_rvalid = st_ff.cfg_rvalid;
  assign port_direction_register = st_ff.dir;
  assign port_function_select_register = st_ff.fsel;
endmodule
`default_nettype wire

// ===== pt_pkg.sv
// shared constants and types for the port latch and input noise filter
// assumes one 20 MHz core clock and a synchronous active-high reset
`default_nettype none
package pt_pkg;
  // ==========================================================
  // port geometry
  localparam int PORT_W = 8;
  localparam int IDX_W = 3;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] DIR_RST = 8'h00; // all pins input, undriven
  localparam logic [7:0] FSEL_RST = 8'h00; // all pins port mode
  localparam logic [7:0] LATCH_RST = 8'h00;
  // single-bit operations on the port data register
  typedef enum logic [1:0] {PT_OP_NONE, PT_OP_SET, PT_OP_CLR, PT_OP_INV} pt_bitop_e;
  // ==========================================================
  // filtered pin groups
  localparam int IRQ_N = 4;
  localparam int TM_N = 3; // timer 10, timer 11, timer 3
  localparam int T2_N = 6;
  // ==========================================================
  // filter configuration register file
  localparam logic [3:0] CFG_TM10 = 4'h0;
  localparam logic [3:0] CFG_TM11 = 4'h1;
  localparam logic [3:0] CFG_TM3 = 4'h2;
  localparam logic [3:0] CFG_T2_BASE = 4'h3; // six registers from here
  localparam logic [3:0] CFG_LAST = 4'h8;
  localparam logic [7:0] CFG_RST = 8'h00;
  // clock select field, both register kinds
  localparam int SEL_LSB = 0;
  localparam int SEL_MSB = 1;
  // timer 2 mode fields
  localparam int T2_DIG_BIT = 2;
  localparam int T2_EDGE_LSB = 4;
  localparam int T2_EDGE_MSB = 5;
  typedef enum logic [1:0] {PT_EDGE_NONE, PT_EDGE_RISE, PT_EDGE_FALL, PT_EDGE_BOTH} pt_edge_e;
  // ==========================================================
  // sampling clocks: tick k fires when the masked divider bits are zero
  localparam int TICK_N = 4;
  localparam int DIV_W = 6;
  localparam logic [DIV_W-1:0] DIV_ZERO = 6'h00;
  localparam logic [DIV_W-1:0] DIV_ONE = 6'h01;
  localparam logic [TICK_N-1:0][DIV_W-1:0] TICK_MASK = {6'h3F, 6'h0F, 6'h03, 6'h00};
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int IRQ_ELIM_NS = 100; // least elimination time of an interrupt pin
  localparam int IRQ_ELIM_CYC = (IRQ_ELIM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TM_ELIM_SAMPLES = 3; // equal samples needed on a timer input
  localparam int FLT_CNT_W = 4;
endpackage
`default_nettype wire

// ===== pt_tick_gen.sv
// free-running divider giving the selectable sampling ticks
// assumes it is reset with the rest of the block and runs on every edge
`default_nettype none
module pt_tick_gen
  import pt_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  output logic [TICK_N-1:0] tick
);
  // ==========================================================
  // state
  typedef struct packed {
    logic [DIV_W-1:0] div; // divider count
  } pt_tick_s;
  pt_tick_s st_ff; // registered state
  pt_tick_s nxt_st; // next state
  // divider just wraps; no enable so ticks stay evenly spaced
  always_comb begin
    nxt_st = st_ff;
    nxt_st.div = st_ff.div + DIV_ONE;
  end
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  // tick k when the low bits selected by its mask are all zero
  always_comb begin
    for (int k = 0; k < TICK_N; k++) begin
      tick[k] = ((st_ff.div & TICK_MASK[k]) == DIV_ZERO);
    end
  end
endmodule
`default_nettype wire

// ===== pt_sample_filter.sv
// one clock-sampled noise filter on an already synchronised level
// assumes din comes from a synchroniser and tick is one cycle wide
`default_nettype none
module pt_sample_filter
  import pt_pkg::*;
#(
  parameter int SAMPLES = TM_ELIM_SAMPLES
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic run,
  input wire logic tick,
  input wire logic din,
  output logic dout
);
  // ==========================================================
  // state
  localparam logic [FLT_CNT_W-1:0] CNT_LAST = FLT_CNT_W'(SAMPLES - 1);
  typedef struct packed {
    logic [FLT_CNT_W-1:0] cnt; // samples seen that differ from dout
    logic level; // accepted level
  } pt_flt_s;
  pt_flt_s st_ff; // registered state
  pt_flt_s nxt_st; // next state
  // a sample equal to dout breaks the run and restarts the count,
  // so only an unbroken interval of equal samples is forwarded
  always_comb begin
    nxt_st = st_ff;
    if (!run) begin
      // stopped: nothing is received while idle
      nxt_st = '0;
    end else if (tick) begin
      if (din == st_ff.level) begin
        nxt_st.cnt = '0;
      end else if (st_ff.cnt == CNT_LAST) begin
        nxt_st.level = din;
        nxt_st.cnt = '0;
      end else begin
        nxt_st.cnt = st_ff.cnt + 1'b1;
      end
    end
  end
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign dout = st_ff.level;
endmodule
`default_nettype wire

// ===== pt_port_filter_checker.sv
// assertions on the port latch and input filter top ports
// assumes binding to pt_port_filter and one clock domain
`default_nettype none
module pt_port_filter_checker
  import pt_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [PORT_W-1:0] port_pin_o,
  input wire logic [PORT_W-1:0] port_pin_oe,
  input wire logic port_wr,
  input wire logic [PORT_W-1:0] port_wdata,
  input wire logic [1:0] port_bit_op,
  input wire logic port_rd,
  input wire logic [PORT_W-1:0] port_rdata,
  input wire logic port_rvalid,
  input wire logic fsel_wr,
  input wire logic dir_wr,
  input wire logic [PORT_W-1:0] dir_wdata,
  input wire logic [PORT_W-1:0] port_direction_register,
  input wire logic [PORT_W-1:0] port_function_select_register,
  input wire logic cfg_rd,
  input wire logic cfg_rvalid,
  input wire logic [IRQ_N-1:0] irq_pin_i,
  input wire logic [IRQ_N-1:0] irq_ctrl_mode,
  input wire logic [IRQ_N-1:0] irq_level,
  input wire logic [IRQ_N-1:0] irq_wake,
  input wire logic [TM_N-1:0] tm_ctrl_mode,
  input wire logic [TM_N-1:0] tm_count_enable,
  input wire logic [TM_N-1:0] tm_level
);
  // ==========================================================
  // one domain; reset mutes every check
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // port latch and readback
  a_rd_answer: assert property (port_rd |=> port_rvalid)
    else $error("port read not answered next cycle");
  a_oe_dir: assert property (dir_wr |=> port_pin_oe == $past(dir_wdata))
    else $error("pin enable differs from direction");
  a_wr_latch: assert property (port_wr && !fsel_wr |=>
    (((port_pin_o ^ $past(port_wdata)) & ~port_function_select_register) == 8'h00))
    else $error("written byte not on port pins");
  a_latch_hold: assert property (!port_wr && port_bit_op == 2'h0 && !fsel_wr |=>
    ((($past(port_pin_o) ^ port_pin_o) & ~port_function_select_register) == 8'h00))
    else $error("latch changed without a write");
  a_rd_view: assert property (port_rd |=>
    (((port_rdata ^ $past(port_pin_o)) & $past(port_pin_oe)) == 8'h00))
    else $error("output bit read differs from drive");
  // ==========================================================
  // filters: wake path and mode gating; config read answer
  a_wake_path: assert property (irq_wake == (irq_pin_i & irq_ctrl_mode))
    else $error("wake path not pin and mode");
  a_irq_gate: assert property ((irq_level & ~$past(irq_ctrl_mode)) == 4'h0)
    else $error("interrupt level passed in port mode");
  a_tm_gate: assert property
    ((tm_level & ~$past(tm_ctrl_mode & tm_count_enable)) == 3'h0)
    else $error("timer level passed while stopped");
  a_cfg_answer: assert property (cfg_rd |=> cfg_rvalid)
    else $error("config read not answered next cycle");
endmodule
bind pt_port_filter pt_port_filter_checker chk_i (.core_clk, .sys_rst, .port_pin_o,
  .port_pin_oe, .port_wr, .port_wdata, .port_bit_op, .port_rd, .port_rdata, .port_rvalid,
  .fsel_wr, .dir_wr, .dir_wdata, .port_direction_register,
  .port_function_select_register, .cfg_rd,
  .cfg_rvalid, .irq_pin_i, .irq_ctrl_mode, .irq_level, .irq_wake, .tm_ctrl_mode,
  .tm_count_enable, .tm_level);
`default_nettype wire

// ===== pt_pin_world.sv
// the board around the port: pins read back their own drive when enabled
// assumes the bench sets ext_level as the outside world's level
`default_nettype none
module pt_pin_world
  import pt_pkg::*;
(
  input wire logic [PORT_W-1:0] pin_o,
  input wire logic [PORT_W-1:0] pin_oe,
  input wire logic [PORT_W-1:0] ext_level,
  output logic [PORT_W-1:0] pin_i
);
  // driven bits show the drive, released bits the outside level
  assign pin_i = (pin_o & pin_oe) | (ext_level & ~pin_oe);
endmodule
`default_nettype wire

// ===== pt_port_filter_tb.sv
// self-checking bench for the port latch and input filters
// assumes package, design, pin model and checker compiled before it
`default_nettype none
module pt_port_filter_tb
  import pt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // stimulus, all valued at time zero
  logic core_clk = 1'h0;
  logic sys_rst = 1'h1;
  logic port_wr = 1'h0, port_rd = 1'h0, dir_wr = 1'h0, fsel_wr = 1'h0;
  logic cfg_wr = 1'h0, cfg_bit_wr = 1'h0, cfg_rd = 1'h0, cfg_bit_val = 1'h0;
  logic [7:0] ext_level = 8'h00, alt_out = 8'h00, port_wdata = 8'h00;
  logic [7:0] dir_wdata = 8'h00, fsel_wdata = 8'h00, cfg_wdata = 8'h00;
  logic [1:0] port_bit_op = 2'h0;
  logic [2:0] port_bit_idx = 3'h0, cfg_bit_idx = 3'h0;
  logic [3:0] cfg_sel = 4'h0, irq_pin_i = 4'h0, irq_ctrl_mode = 4'h0;
  logic [2:0] tm_pin_i = 3'h0, tm_ctrl_mode = 3'h0, tm_count_enable = 3'h0;
  logic [5:0] t2_pin_i = 6'h00, t2_ctrl_mode = 6'h00, t2_en = 6'h00;
  // design outputs
  logic [7:0] port_pin_i, port_pin_o, port_pin_oe, port_rdata, cfg_rdata;
  logic [7:0] port_direction_register, port_function_select_register;
  logic port_rvalid, cfg_rvalid;
  logic [3:0] irq_level, irq_wake;
  logic [2:0] tm_level;
  logic [5:0] t2_level, t2_edge;
  int mismatches = 0, num_checks = 0, cycles = 0;
  // ==========================================================
  // design and board
  pt_port_filter dut (.core_clk, .sys_rst, .port_pin_i, .port_pin_o, .port_pin_oe, .alt_out,
    .port_wr, .port_wdata, .port_bit_op, .port_bit_idx, .port_rd, .port_rdata, .port_rvalid,
    .dir_wr, .dir_wdata, .fsel_wr, .fsel_wdata, .port_direction_register,
    .port_function_select_register, .cfg_wr, .cfg_bit_wr, .cfg_sel, .cfg_wdata,
    .cfg_bit_idx, .cfg_bit_val, .cfg_rd, .cfg_rdata, .cfg_rvalid, .irq_pin_i,
    .irq_ctrl_mode, .irq_level, .irq_wake, .tm_pin_i, .tm_ctrl_mode, .tm_count_enable,
    .tm_level, .t2_pin_i, .t2_ctrl_mode, .timer2_channel_count_enable(t2_en), .t2_level,
    .t2_edge);
  pt_pin_world pins (.pin_o(port_pin_o), .pin_oe(port_pin_oe), .ext_level,
    .pin_i(port_pin_i));
  // 20 MHz clock
  always #25 core_clk = ~core_clk;
  // hang guard, well above the scenarios' length
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      summarize();
    end
  end
  // ==========================================================
  // shared helpers
  task automatic summarize();
    if (mismatches == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // direction and function select written together
  task automatic set_mode(input logic [7:0] d, input logic [7:0] f);
    @(posedge core_clk);
    dir_wr <= 1'h1;
    dir_wdata <= d;
    fsel_wr <= 1'h1;
    fsel_wdata <= f;
    @(posedge core_clk);
    dir_wr <= 1'h0;
    fsel_wr <= 1'h0;
    #1;
  endtask
  task automatic wr_port(input logic [7:0] d);
    @(posedge core_clk);
    port_wr <= 1'h1;
    port_wdata <= d;
    @(posedge core_clk);
    port_wr <= 1'h0;
    #1;
  endtask
  task automatic bit_op(input pt_bitop_e op, input logic [2:0] i);
    @(posedge core_clk);
    port_bit_op <= op;
    port_bit_idx <= i;
    @(posedge core_clk);
    port_bit_op <= PT_OP_NONE;
    #1;
  endtask
  // read answered on the taking edge, checked just after it
  task automatic rd_port(input logic [7:0] e);
    @(posedge core_clk);
    port_rd <= 1'h1;
    @(posedge core_clk);
    port_rd <= 1'h0;
    #1;
    chk("port_rvalid", 8'h01, 8'(port_rvalid));
    chk("port_rdata", e, port_rdata);
  endtask
  task automatic wr_cfg(input logic [3:0] s, input logic [7:0] d);
    @(posedge core_clk);
    cfg_wr <= 1'h1;
    cfg_sel <= s;
    cfg_wdata <= d;
    @(posedge core_clk);
    cfg_wr <= 1'h0;
    #1;
  endtask
  task automatic rd_cfg(input logic [3:0] s, input logic [7:0] e);
    @(posedge core_clk);
    cfg_rd <= 1'h1;
    cfg_sel <= s;
    @(posedge core_clk);
    cfg_rd <= 1'h0;
    #1;
    chk("cfg_rvalid", 8'h01, 8'(cfg_rvalid));
    chk("cfg_rdata", e, cfg_rdata);
  endtask
  // legal value per register: clock select, or mode with edge field
  function automatic logic [7:0] cfg_val(input int s);
    return (s < 3) ? 8'(s + 1) : 8'(8'h30 + s - 3);
  endfunction
  // ==========================================================
  // scenarios
  task automatic t_reset();
    for (int s = 0; s < 9; s++) rd_cfg(4'(s), 8'h00);
    chk("port_pin_oe", 8'h00, port_pin_oe);
  endtask
  task automatic t_out();
    set_mode(8'hFF, 8'h00);
    wr_port(8'hA5);
    chk("port_pin_o", 8'hA5, port_pin_o);
    repeat (5) @(posedge core_clk);
    #1;
    chk("port_pin_o", 8'hA5, port_pin_o);
    rd_port(8'hA5);
  endtask
  task automatic t_in();
    @(posedge core_clk);
    ext_level <= 8'h90;
    set_mode(8'h0F, 8'h00);
    wr_port(8'h3C);
    chk("port_pin_oe", 8'h0F, port_pin_oe);
    chk("port_direction_register", 8'h0F, port_direction_register);
    rd_port(8'h9C);
    set_mode(8'hFF, 8'h00);
    rd_port(8'h3C);
  endtask
  task automatic t_bitop();
    pt_bitop_e ops[3] = '{PT_OP_SET, PT_OP_CLR, PT_OP_INV};
    logic [2:0] idx[3] = '{3'h0, 3'h7, 3'h1};
    logic [7:0] exp[3] = '{8'hA1, 8'h21, 8'hA3};
    @(posedge core_clk);
    ext_level <= 8'hA0;
    set_mode(8'h0F, 8'h00);
    wr_port(8'h00);
    for (int k = 0; k < 3; k++) begin
      bit_op(ops[k], idx[k]);
      chk("port_pin_o", exp[k], port_pin_o);
    end
  endtask
  task automatic t_alt();
    @(posedge core_clk);
    alt_out <= 8'h5A;
    ext_level <= 8'h03;
    set_mode(8'hF0, 8'hFF);
    rd_port(8'h53);
    chk("port_pin_o", 8'h5A, port_pin_o);
    chk("port_function_select_register", 8'hFF, port_function_select_register);
  endtask
  task automatic t_irq();
    @(posedge core_clk);
    irq_ctrl_mode <= 4'h1;
    irq_pin_i <= 4'h1;
    @(posedge core_clk);
    irq_pin_i <= 4'h0;
    repeat (8) @(posedge core_clk);
    #1;
    chk("irq_level", 8'h00, 8'(irq_level));
    @(posedge core_clk);
    irq_pin_i <= 4'h1;
    #1;
    chk("irq_wake", 8'h01, 8'(irq_wake));
    for (int n = 0; n < 10 && irq_level !== 4'h1; n++) begin
      @(posedge core_clk);
      #1;
    end
    chk("irq_level", 8'h01, 8'(irq_level));
    @(posedge core_clk);
    irq_ctrl_mode <= 4'h0;
    repeat (3) @(posedge core_clk);
    #1;
    chk("irq_level", 8'h00, 8'(irq_level));
  endtask
  task automatic t_tm();
    @(posedge core_clk);
    tm_ctrl_mode <= 3'h1;
    tm_pin_i <= 3'h1;
    repeat (20) @(posedge core_clk);
    #1;
    chk("tm_level", 8'h00, 8'(tm_level));
    @(posedge core_clk);
    tm_count_enable <= 3'h1;
    tm_pin_i <= 3'h0;
    repeat (6) @(posedge core_clk);
    tm_pin_i <= 3'h1;
    @(posedge core_clk);
    tm_pin_i <= 3'h0;
    repeat (10) @(posedge core_clk);
    #1;
    chk("tm_level", 8'h00, 8'(tm_level));
    @(posedge core_clk);
    tm_pin_i <= 3'h1;
    for (int n = 0; n < 12 && tm_level !== 3'h1; n++) begin
      @(posedge core_clk);
      #1;
    end
    chk("tm_level", 8'h01, 8'(tm_level));
    wr_cfg(CFG_TM10, 8'h03);
    @(posedge core_clk);
    tm_pin_i <= 3'h0;
    repeat (60) @(posedge core_clk);
    #1;
    chk("tm_level", 8'h01, 8'(tm_level));
    for (int n = 0; n < 250 && tm_level !== 3'h0; n++) begin
      @(posedge core_clk);
      #1;
    end
    chk("tm_level", 8'h00, 8'(tm_level));
  endtask
  task automatic t_t2();
    logic seen = 1'h0;
    @(posedge core_clk);
    t2_ctrl_mode <= 6'h01;
    t2_en <= 6'h01;
    wr_cfg(CFG_T2_BASE, 8'h10);
    @(posedge core_clk);
    t2_pin_i <= 6'h01;
    for (int n = 0; n < 10 && !seen; n++) begin
      @(posedge core_clk);
      #1;
      seen = (t2_edge[0] === 1'h1);
    end
    chk("t2_edge", 8'h01, 8'(seen));
    wr_cfg(CFG_T2_BASE, 8'h14);
    @(posedge core_clk);
    t2_pin_i <= 6'h00;
    @(posedge core_clk);
    t2_pin_i <= 6'h01;
    seen = 1'h0;
    for (int n = 0; n < 10; n++) begin
      @(posedge core_clk);
      #1;
      seen = seen | (t2_edge[0] === 1'h1);
    end
    chk("t2_edge", 8'h00, 8'(seen));
    chk("t2_level", 8'h01, 8'(t2_level));
  endtask
  task automatic t_cfg();
    for (int s = 0; s < 9; s++) wr_cfg(4'(s), cfg_val(s));
    for (int s = 0; s < 9; s++) rd_cfg(4'(s), cfg_val(s));
    @(posedge core_clk);
    cfg_bit_wr <= 1'h1;
    cfg_sel <= CFG_T2_BASE;
    cfg_bit_idx <= 3'h2;
    cfg_bit_val <= 1'h1;
    @(posedge core_clk);
    cfg_bit_wr <= 1'h0;
    rd_cfg(CFG_T2_BASE, 8'h34);
    rd_cfg(4'hF, 8'h00);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'h0;
    t_reset();
    t_out();
    t_in();
    t_bitop();
    t_alt();
    t_irq();
    t_tm();
    t_t2();
    t_cfg();
    summarize();
  end
endmodule
`default_nettype wire
